// ### verilog/ep_tx_pkg.sv
// Constants shared by the endpoint transmit control block
package ep_tx_pkg;
  localparam int          NUM_EP        = 16;
  localparam int          EP_IDX_W      = 4;
  // Register map, byte offsets on the plain register port
  localparam logic [7:0]  TX_CTRL_BASE  = 8'hf0;  // endpoint_tx_control, index 0..15
  localparam logic [7:0]  RX_STAT_BASE  = 8'he0;  // endpoint_rx_control status copy
  localparam logic [7:0]  IRQ_CFG_OFS   = 8'hd0;  // group enables and priorities
  localparam logic [7:0]  TX_CTRL_RST   = 8'h00;
  localparam logic [7:0]  IRQ_CFG_RST   = 8'h00;
  // Field positions of endpoint_tx_control
  localparam int          F_DONE        = 7;
  localparam int          F_TOG         = 6;
  localparam int          F_STAT_HI     = 5;
  localparam int          F_STAT_LO     = 4;
  localparam int          F_KIND_HI     = 3;
  localparam int          F_KIND_LO     = 2;
  localparam int          F_CTRL_EP     = 1;
  localparam int          F_ISO         = 0;
  // Field positions of the group configuration register
  localparam int          F_TIMED_EN    = 7;
  localparam int          F_UNTIMED_EN  = 3;
  // Status codes, both directions
  localparam logic [1:0]  ST_DISABLED   = 2'h0;
  localparam logic [1:0]  ST_STALL      = 2'h1;
  localparam logic [1:0]  ST_NAK        = 2'h2;
  localparam logic [1:0]  ST_VALID      = 2'h3;
  // Token kinds, upper two PID bits
  localparam logic [1:0]  TOK_OUT       = 2'h0;
  localparam logic [1:0]  TOK_IN        = 2'h2;
  localparam logic [1:0]  TOK_SETUP     = 2'h3;
  // Link events
  typedef enum logic [2:0] {
    EV_NONE     = 3'h0,
    EV_TOKEN    = 3'h1,   // token addressed to endpoint, kind on tok_kind
    EV_TX_END   = 3'h2,   // data packet sent
    EV_ACK      = 3'h3,   // host handshake ACK after our data
    EV_RX_OK    = 3'h4,   // OUT/SETUP data received and accepted
    EV_FAIL     = 3'h5    // NAK, STALL, error or toggle mismatch
  } link_ev_t;
  // Answer to a token
  typedef enum logic [2:0] {
    ANS_NONE    = 3'b001,
    ANS_NAK     = 3'b010,
    ANS_STALL   = 3'b100,
    ANS_DATA    = 3'b011,
    ANS_ACCEPT  = 3'b101
  } answer_t;
endpackage

// ### verilog/ep_tx_ctrl.sv
// Per-endpoint transmit control registers with token flow control
// Operation
// R1 - Hardware sets done flag bit 7 on successful transaction; software only clears
// R2 - NAK, STALL, protocol error or toggle mismatch leave done flag untouched
// R3 - Done flag set on non-iso endpoint: NAK all, silently drop SETUP
// R4 - Registers zero on reset, bus reset, forced reset; bus resets spare done flag
// R5 - Non-iso toggle picks DATA0/DATA1 and flips on host ACK
// R6 - SETUP to control endpoint forces transmit toggle to 1
// R7 - Iso endpoint sends DATA0 only and flips toggle at packet end
// R8 - Software initialises toggle before using non-control endpoints
// R9 - Status 00 ignore, 01 STALL, 10 NAK, 11 transmit on IN
// R10 - Successful IN, or SETUP on control endpoint, sets status to NAK
// R11 - Iso endpoints never get hardware status changes
// R12 - Last token kind captured in bits 3:2, frozen while done flag set
// R13 - Token kind reads 00 OUT, 10 IN, 11 SETUP
// R14 - Control endpoint with receive NAK gives no answer to SETUP
// R15 - Control endpoint with receive STALL still accepts SETUP and completes
// R16 - Software programs only 00 or 11 status on iso endpoints
// R17 - Iso toggle 0: link uses transmit descriptors; 1: receive descriptors
// R18 - Software keeps iso endpoints one-directional
// R19 - Sixteen independent registers indexed by endpoint 0 to 15
// R20 - Software sets bit 1 for control, bit 0 for isochronous
// R21 - Separate done-event enables and 3-bit priorities for iso and non-iso groups
// R22 - Writing 1 to done flag keeps it; only 0 clears
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps

module ep_tx_ctrl
  import ep_tx_pkg::*;
#(
  parameter int NEP = ep_tx_pkg::NUM_EP
) (
  // Clock and resets
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  input  wire logic                       bus_reset,
  // Register port
  input  wire logic [7:0]                 reg_addr,
  input  wire logic [7:0]                 reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [7:0]                 reg_rdata,
  // Link event from the serial engine
  input  wire ep_tx_pkg::link_ev_t        link_ev,
  input  wire logic [ep_tx_pkg::EP_IDX_W-1:0] link_ep,
  input  wire logic [1:0]                 tok_kind,
  // Answer to the current token
  output ep_tx_pkg::answer_t              link_answer,
  output logic                            tx_data_pid,
  output logic                            use_rx_desc,
  // Completion event toward the interrupt unit
  output logic                            done_event,
  output logic [2:0]                      done_prio
);
  import ep_tx_pkg::*;

  // Index decode and the register array assume one register per endpoint id
  if (NEP < 1 || NEP > NUM_EP) begin : g_nep_check
    $error("NEP out of range");
  end

  // ==========================================================
  // Register state
  logic [7:0] tx_r     [NEP];
  logic [7:0] tx_nxt   [NEP];
  logic [1:0] rxst_r   [NEP];
  logic [1:0] rxst_nxt [NEP];
  logic [7:0] cfg_r, cfg_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic       done_ev_r, done_ev_nxt;
  logic [2:0] prio_r, prio_nxt;

  // ==========================================================
  // Decode of the addressed endpoint
  logic [7:0] cur;
  logic [1:0] cur_rx;
  logic       iso_c, ctl_c, done_c, setup_c;
  logic       sel_ok;
  logic [3:0] widx;
  logic       wsel_tx, wsel_rx;

  always_comb begin
    sel_ok  = (int'(link_ep) < NEP);
    cur     = sel_ok ? tx_r[link_ep] : TX_CTRL_RST;
    cur_rx  = sel_ok ? rxst_r[link_ep] : ST_DISABLED;
    iso_c   = cur[F_ISO];
    ctl_c   = cur[F_CTRL_EP];
    done_c  = cur[F_DONE];
    setup_c = (tok_kind == TOK_SETUP);
    widx    = reg_addr[3:0];
    wsel_tx = reg_wr && (reg_addr[7:4] == TX_CTRL_BASE[7:4]) && (int'(widx) < NEP);
    wsel_rx = reg_wr && (reg_addr[7:4] == RX_STAT_BASE[7:4]) && (int'(widx) < NEP);
  end

  // ==========================================================
  // Answer to a token: decided combinationally in the token cycle
  always_comb begin
    link_answer = ANS_NONE;
    if (link_ev == EV_TOKEN && sel_ok) begin
      if (setup_c) begin
        if (!ctl_c || done_c) link_answer = ANS_NONE;            // R3
        else if (cur_rx == ST_NAK) link_answer = ANS_NONE;        // R14
        else if (cur_rx != ST_DISABLED) link_answer = ANS_ACCEPT; // R15
      end else if (done_c && !iso_c) begin
        link_answer = ANS_NAK;                                    // R3
      end else if (tok_kind == TOK_IN) begin
        unique case (cur[F_STAT_HI:F_STAT_LO])                   // R9
          ST_DISABLED: link_answer = ANS_NONE;
          ST_STALL:    link_answer = ANS_STALL;
          ST_NAK:      link_answer = ANS_NAK;
          ST_VALID:    link_answer = ANS_DATA;
        endcase
      end
    end
  end

  // Iso always DATA0; toggle then picks the descriptor pair
  always_comb begin
    tx_data_pid = iso_c ? 1'b0 : cur[F_TOG];                      // R5 R7
    use_rx_desc = iso_c & cur[F_TOG];                             // R17
  end

  // ==========================================================
  // Next state of the endpoint registers
  always_comb begin
    logic [7:0] v;
    logic       ok;
    v = TX_CTRL_RST;
    ok = 1'b0;
    cfg_nxt     = cfg_r;
    done_ev_nxt = 1'b0;
    prio_nxt    = prio_r;
    for (int i = 0; i < NEP; i++) begin
      v = tx_r[i];
      rxst_nxt[i] = rxst_r[i];
      // Software write; done flag can only be cleared
      if (wsel_tx && int'(widx) == i) begin
        v[F_TOG]              = reg_wdata[F_TOG];                 // R8
        v[F_STAT_HI:F_STAT_LO] = reg_wdata[F_STAT_HI:F_STAT_LO];
        v[F_CTRL_EP]          = reg_wdata[F_CTRL_EP];             // R20
        v[F_ISO]              = reg_wdata[F_ISO];
        if (!reg_wdata[F_DONE]) v[F_DONE] = 1'b0;                 // R22
      end
      if (wsel_rx && int'(widx) == i) rxst_nxt[i] = reg_wdata[1:0];
      // Link events; hardware set wins over software clear
      if (sel_ok && int'(link_ep) == i) begin
        ok = 1'b0;
        unique case (link_ev)
          EV_TOKEN: begin
            if (!tx_r[i][F_DONE])
              v[F_KIND_HI:F_KIND_LO] = tok_kind;                  // R12 R13
            if (setup_c && tx_r[i][F_CTRL_EP] && !tx_r[i][F_DONE])
              v[F_TOG] = 1'b1;                                    // R6
          end
          EV_TX_END: begin
            if (tx_r[i][F_ISO]) begin
              v[F_TOG] = ~tx_r[i][F_TOG];                         // R7
              ok = 1'b1;
            end
          end
          EV_ACK: begin
            if (!tx_r[i][F_ISO]) begin
              v[F_TOG] = ~tx_r[i][F_TOG];                         // R5
              ok = 1'b1;
              v[F_STAT_HI:F_STAT_LO] = ST_NAK;                    // R10
            end
          end
          EV_RX_OK: begin
            ok = 1'b1;
            if (tx_r[i][F_KIND_HI:F_KIND_LO] == TOK_SETUP && tx_r[i][F_CTRL_EP]
                && !tx_r[i][F_ISO])
              v[F_STAT_HI:F_STAT_LO] = ST_NAK;                    // R10 R11
          end
          EV_FAIL: ok = 1'b0;                                     // R2
          default: ok = 1'b0;
        endcase
        if (ok) begin
          v[F_DONE] = 1'b1;                                       // R1
          if (tx_r[i][F_ISO] ? cfg_r[F_TIMED_EN] : cfg_r[F_UNTIMED_EN]) begin
            done_ev_nxt = 1'b1;                                   // R21
            prio_nxt = tx_r[i][F_ISO] ? cfg_r[6:4] : cfg_r[2:0];
          end
        end
      end
      tx_nxt[i] = v;
    end
    if (reg_wr && reg_addr == IRQ_CFG_OFS) cfg_nxt = reg_wdata;
    // Bus or forced reset: clear endpoint registers but their done flag, and receive status; group config kept
    if (bus_reset) begin
      for (int i = 0; i < NEP; i++) begin
        tx_nxt[i] = {tx_r[i][F_DONE], 7'h00};                     // R4
        rxst_nxt[i] = ST_DISABLED;
      end
    end
  end

  // ==========================================================
  // Read path, data stands one cycle after the strobe
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      if (reg_addr[7:4] == TX_CTRL_BASE[7:4] && int'(reg_addr[3:0]) < NEP)
        rdata_nxt = tx_r[reg_addr[3:0]];                          // R19
      else if (reg_addr[7:4] == RX_STAT_BASE[7:4] && int'(reg_addr[3:0]) < NEP)
        rdata_nxt = {6'h00, rxst_r[reg_addr[3:0]]};
      else if (reg_addr == IRQ_CFG_OFS)
        rdata_nxt = cfg_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < NEP; i++) begin
        tx_r[i]   <= TX_CTRL_RST;                                 // R4
        rxst_r[i] <= ST_DISABLED;
      end
      cfg_r     <= IRQ_CFG_RST;
      rdata_r   <= 8'h00;
      done_ev_r <= 1'b0;
      prio_r    <= 3'h0;
    end else begin
      for (int i = 0; i < NEP; i++) begin
        tx_r[i]   <= tx_nxt[i];
        rxst_r[i] <= rxst_nxt[i];
      end
      cfg_r     <= cfg_nxt;
      rdata_r   <= rdata_nxt;
      done_ev_r <= done_ev_nxt;
      prio_r    <= prio_nxt;
    end
  end

  assign reg_rdata  = rdata_r;
  assign done_event = done_ev_r;
  assign done_prio  = prio_r;

  // ==========================================================
  // Checks
  a_done_sets: assert property (@(posedge clk_sys) disable iff (rst)   // R1
    (link_ev == EV_ACK && sel_ok && !iso_c && !bus_reset) |=> tx_r[$past(link_ep)][F_DONE])
    else $error("done flag not set after ACK");
  a_fail_keeps: assert property (@(posedge clk_sys) disable iff (rst)  // R2
    (link_ev == EV_FAIL && sel_ok && !reg_wr && !bus_reset)
      |=> tx_r[$past(link_ep)] == $past(cur))
    else $error("failed transaction changed register");
  a_done_nak: assert property (@(posedge clk_sys) disable iff (rst)    // R3
    (link_ev == EV_TOKEN && sel_ok && done_c && !iso_c && tok_kind == TOK_IN)
      |-> link_answer == ANS_NAK)
    else $error("pending completion not NAKed");
  a_busrst_keep: assert property (@(posedge clk_sys) disable iff (rst) // R4
    bus_reset |=> tx_r[0] == {$past(tx_r[0][F_DONE]), 7'h00})
    else $error("bus reset handled wrongly");
  a_ack_toggle: assert property (@(posedge clk_sys) disable iff (rst)  // R5
    (link_ev == EV_ACK && sel_ok && !iso_c && !bus_reset && !reg_wr)
      |=> tx_r[$past(link_ep)][F_TOG] != $past(cur[F_TOG]))
    else $error("toggle not inverted on ACK");
  a_setup_tog: assert property (@(posedge clk_sys) disable iff (rst)   // R6
    (link_ev == EV_TOKEN && sel_ok && setup_c && ctl_c && !done_c && !bus_reset)
      |=> tx_r[$past(link_ep)][F_TOG])
    else $error("SETUP did not force toggle");
  a_iso_pid: assert property (@(posedge clk_sys) disable iff (rst)     // R7
    iso_c |-> !tx_data_pid)
    else $error("iso endpoint sent DATA1");
  a_in_nak: assert property (@(posedge clk_sys) disable iff (rst)      // R10
    (link_ev == EV_ACK && sel_ok && !iso_c && !bus_reset && !reg_wr)
      |=> tx_r[$past(link_ep)][F_STAT_HI:F_STAT_LO] == ST_NAK)
    else $error("status not NAK after IN");
  a_kind_frozen: assert property (@(posedge clk_sys) disable iff (rst) // R12
    (link_ev == EV_TOKEN && sel_ok && done_c && !bus_reset)
      |=> tx_r[$past(link_ep)][F_KIND_HI:F_KIND_LO] == $past(cur[F_KIND_HI:F_KIND_LO]))
    else $error("token kind changed while done");
  a_wr_one: assert property (@(posedge clk_sys) disable iff (rst)      // R22
    (wsel_tx && tx_r[widx][F_DONE] && reg_wdata[F_DONE] && !bus_reset)
      |=> tx_r[$past(widx)][F_DONE])
    else $error("writing one cleared done flag");

  // ==========================================================
  // Token answers, judged in the token cycle since the answer is combinational
  a_setup_drop: assert property (@(posedge clk_sys) disable iff (rst)  // R3
    (link_ev == EV_TOKEN && sel_ok && setup_c && done_c) |-> link_answer == ANS_NONE)
    else $error("SETUP answered while done");
  a_in_stall: assert property (@(posedge clk_sys) disable iff (rst)    // R9
    (link_ev == EV_TOKEN && sel_ok && tok_kind == TOK_IN && !done_c
      && cur[F_STAT_HI:F_STAT_LO] == ST_STALL) |-> link_answer == ANS_STALL)
    else $error("stalled endpoint did not stall");
  a_setup_quiet: assert property (@(posedge clk_sys) disable iff (rst) // R14
    (link_ev == EV_TOKEN && sel_ok && setup_c && ctl_c && cur_rx == ST_NAK)
      |-> link_answer == ANS_NONE)
    else $error("SETUP answered with receive NAK");
  a_stall_accept: assert property (@(posedge clk_sys) disable iff (rst) // R15
    (link_ev == EV_TOKEN && sel_ok && setup_c && ctl_c && !done_c && cur_rx == ST_STALL)
      |-> link_answer == ANS_ACCEPT)
    else $error("SETUP refused with receive STALL");

  // Register effects of link events, one cycle after the event
  a_iso_flip: assert property (@(posedge clk_sys) disable iff (rst)    // R7
    (link_ev == EV_TX_END && sel_ok && iso_c && !bus_reset && !reg_wr)
      |=> tx_r[$past(link_ep)][F_TOG] != $past(cur[F_TOG]))
    else $error("iso toggle not inverted at packet end");
  a_iso_status: assert property (@(posedge clk_sys) disable iff (rst)  // R11
    (link_ev != EV_NONE && sel_ok && iso_c && !bus_reset && !reg_wr)
      |=> tx_r[$past(link_ep)][F_STAT_HI:F_STAT_LO] == $past(cur[F_STAT_HI:F_STAT_LO]))
    else $error("iso status changed by hardware");
  a_kind_capture: assert property (@(posedge clk_sys) disable iff (rst) // R12
    (link_ev == EV_TOKEN && sel_ok && !done_c && !bus_reset)
      |=> tx_r[$past(link_ep)][F_KIND_HI:F_KIND_LO] == $past(tok_kind))
    else $error("token kind not captured");
  a_done_event: assert property (@(posedge clk_sys) disable iff (rst)  // R21
    (link_ev == EV_ACK && sel_ok && !iso_c && cfg_r[F_UNTIMED_EN])
      |=> done_event && done_prio == $past(cfg_r[2:0]))
    else $error("completion event or priority wrong");
endmodule // ep_tx_ctrl

// ### tb/usb_host_model.sv
// Host-side link engine model issuing tokens and handshakes
`timescale 1ns/1ps

module usb_host_model (
  // Clock
  input  wire logic                clk_sys,
  // Link events toward the block
  output ep_tx_pkg::link_ev_t      link_ev,
  output logic [3:0]               link_ep,
  output logic [1:0]               tok_kind
);
  import ep_tx_pkg::*;

  initial begin
    link_ev  = EV_NONE;
    link_ep  = 4'h0;
    tok_kind = 2'h0;
  end

  // Raise one event right after an edge; it is taken at the next edge
  task automatic start(input link_ev_t e, input logic [3:0] ep, input logic [1:0] k);
    @(posedge clk_sys);
    link_ev  <= e;
    link_ep  <= ep;
    tok_kind <= k;
  endtask

  // Kind and index are inverted so the old values do not linger while no event is raised
  task automatic finish();
    @(posedge clk_sys);
    link_ev  <= EV_NONE;
    link_ep  <= ~link_ep;
    tok_kind <= ~tok_kind;
  endtask
endmodule // usb_host_model

// ### tb/tb_top.sv
// Self-checking bench for the endpoint transmit control block
`timescale 1ns/1ps

module tb_top;
  import ep_tx_pkg::*;
  logic       clk_sys   = 1'b0;
  logic       rst       = 1'b1;
  logic       bus_reset = 1'b0;
  logic [7:0] reg_addr  = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic [7:0] reg_rdata;
  link_ev_t   link_ev;
  logic [3:0] link_ep;
  logic [1:0] tok_kind;
  answer_t    link_answer;
  logic       tx_data_pid;
  logic       use_rx_desc;
  logic       done_event;
  logic [2:0] done_prio;
  int         error_cnt = 0;
  int         n_tests   = 0;
  answer_t    ans_tbl[4] = '{ANS_NONE, ANS_STALL, ANS_NAK, ANS_DATA};

  ep_tx_ctrl DUT (
    .clk_sys(clk_sys), .rst(rst), .bus_reset(bus_reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .link_ev(link_ev), .link_ep(link_ep), .tok_kind(tok_kind),
    .link_answer(link_answer), .tx_data_pid(tx_data_pid), .use_rx_desc(use_rx_desc),
    .done_event(done_event), .done_prio(done_prio)
  );

  usb_host_model host (
    .clk_sys(clk_sys), .link_ev(link_ev), .link_ep(link_ep), .tok_kind(tok_kind)
  );

  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // Compare and bus tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_ans(input answer_t got, input answer_t exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: answer %b want %b", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 chk(reg_rdata, exp, "register");
  endtask

  // One link event; pr is {use_rx_desc, tx_data_pid} in the event cycle
  task automatic ev(input link_ev_t e, input logic [3:0] ep, input logic [1:0] k,
                    input answer_t ans, input logic [1:0] pr, input logic de);
    host.start(e, ep, k);
    #5 chk_ans(link_answer, ans);
    chk({6'h00, use_rx_desc, tx_data_pid}, {6'h00, pr}, "pid");
    host.finish();
    #1 chk({7'h00, done_event}, {7'h00, de}, "done event");
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rdc(8'hf0, 8'h00);
    rdc(8'hff, 8'h00);
    wr(8'h10, 8'hff);
    rdc(8'h10, 8'h00);
    wr(8'hff, 8'h42);
    rdc(8'hff, 8'h42);
    rdc(8'hf0, 8'h00);
    wr(8'hd0, 8'h8d);
    rdc(8'hd0, 8'h8d);
  endtask

  task automatic t_in();
    wr(8'hf1, 8'h30);
    ev(EV_TOKEN, 4'h1, TOK_IN, ANS_DATA, 2'b00, 1'b0);
    rdc(8'hf1, 8'h38);
    ev(EV_ACK, 4'h1, 2'h0, ANS_NONE, 2'b00, 1'b1);
    chk({5'h00, done_prio}, 8'h05, "prio");
    rdc(8'hf1, 8'he8);
  endtask

  task automatic t_flow();
    ev(EV_TOKEN, 4'h1, TOK_IN, ANS_NAK, 2'b01, 1'b0);
    ev(EV_TOKEN, 4'h1, TOK_SETUP, ANS_NONE, 2'b01, 1'b0);
    rdc(8'hf1, 8'he8);
    ev(EV_FAIL, 4'h1, 2'h0, ANS_NONE, 2'b01, 1'b0);
    rdc(8'hf1, 8'he8);
    wr(8'hf1, 8'hb0);
    rdc(8'hf1, 8'hb8);
    wr(8'hf1, 8'h70);
    ev(EV_TOKEN, 4'h1, TOK_OUT, ANS_NONE, 2'b01, 1'b0);
    rdc(8'hf1, 8'h70);
  endtask

  task automatic t_status();
    for (int i = 0; i < 4; i++) begin
      wr(8'hf2, {2'b00, i[1:0], 4'h0});
      ev(EV_TOKEN, 4'h2, TOK_IN, ans_tbl[i], 2'b00, 1'b0);
    end
  endtask

  task automatic t_setup();
    wr(8'he3, 8'h01);
    wr(8'hf3, 8'h02);
    ev(EV_TOKEN, 4'h3, TOK_SETUP, ANS_ACCEPT, 2'b00, 1'b0);
    rdc(8'hf3, 8'h4e);
    ev(EV_RX_OK, 4'h3, 2'h0, ANS_NONE, 2'b01, 1'b1);
    rdc(8'hf3, 8'hee);
    ev(EV_TOKEN, 4'h3, TOK_SETUP, ANS_NONE, 2'b01, 1'b0);
    ev(EV_TOKEN, 4'h3, TOK_OUT, ANS_NAK, 2'b01, 1'b0);
    rdc(8'hf3, 8'hee);
    wr(8'he4, 8'h02);
    wr(8'hf4, 8'h02);
    ev(EV_TOKEN, 4'h4, TOK_SETUP, ANS_NONE, 2'b00, 1'b0);
  endtask

  task automatic t_iso();
    wr(8'hd0, 8'hcd);
    wr(8'hf5, 8'h31);
    ev(EV_TOKEN, 4'h5, TOK_IN, ANS_DATA, 2'b00, 1'b0);
    ev(EV_TX_END, 4'h5, 2'h0, ANS_NONE, 2'b00, 1'b1);
    chk({5'h00, done_prio}, 8'h04, "prio");
    rdc(8'hf5, 8'hf9);
    ev(EV_TOKEN, 4'h5, TOK_IN, ANS_DATA, 2'b10, 1'b0);
  endtask

  task automatic t_bus_reset();
    @(posedge clk_sys);
    bus_reset <= 1'b1;
    @(posedge clk_sys);
    bus_reset <= 1'b0;
    rdc(8'hf5, 8'h80);
    rdc(8'hf3, 8'h80);
    rdc(8'hd0, 8'hcd);
  endtask

  task automatic stop_test();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_in();
    t_flow();
    t_status();
    t_setup();
    t_iso();
    t_bus_reset();
    stop_test();
  end

  // The whole sequence needs about 115 cycles, well under the 2500-cycle limit
  initial begin
    #100000;
    error_cnt++;
    stop_test();
  end
endmodule // tb_top
